// file: core/pms_consts.vh
/*
 * constants of the operating-mode controller: register map, field positions,
 * reset values and timing counts.
 * assumes a 100 MHz clock and a 32-bit Avalon-MM slave with word addresses in bytes.
 */
`ifndef PMS_CONSTS_VH
`define PMS_CONSTS_VH

`define PMS_CLK_MHZ          100
// times in their own unit
`define PMS_WAKE_DEGLITCH_NS 93750
`define PMS_VCSW_DEGLITCH_NS 62520
`define PMS_WAKE_DELAY_US    5500
`define PMS_STEP_DELAY_US    1000
// derived cycle counts (least times round up)
`define PMS_WAKE_DEGLITCH_CYC ((`PMS_WAKE_DEGLITCH_NS * `PMS_CLK_MHZ + 999) / 1000)
`define PMS_VCSW_DEGLITCH_CYC ((`PMS_VCSW_DEGLITCH_NS * `PMS_CLK_MHZ + 999) / 1000)
`define PMS_WAKE_DELAY_CYC    (`PMS_WAKE_DELAY_US * `PMS_CLK_MHZ)
`define PMS_STEP_DELAY_CYC    (`PMS_STEP_DELAY_US * `PMS_CLK_MHZ)

// register byte offsets
`define PMS_REG_ENABLE   4'h0
`define PMS_REG_SEQ      4'h4
`define PMS_REG_TEMP     4'h8
`define PMS_REG_STATUS   4'hc

// command register fields
`define PMS_EN_ACTIVE_BIT  0
`define PMS_EN_STANDBY_BIT 1

// thresholds and reset values
`define PMS_HOT_DEFAULT  8'h8c
`define PMS_COOL_DEFAULT 8'h82
`define PMS_SEQ_DEFAULT  8'he4

// mode codes
`define PMS_MODE_SLEEP   2'h0
`define PMS_MODE_STANDBY 2'h1
`define PMS_MODE_ACTIVE  2'h2

`endif

// file: core/pms_mode_ctrl.v
/*
 * operating-mode controller: sleep / standby / active, rail enables, fault
 * forcing, register sequencing and thermistor hot flag with hysteresis.
 * assumes pins are asynchronous to clk and faults / temperature are levels
 * from other blocks; software reaches registers over Avalon-MM.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pms_consts.vh"

// Contract
// (RQ1) exactly three modes: sleep, standby, active
// (RQ2) sleep holds registers at default and ignores every bus access
// (RQ3) wake pin low sends device to sleep from any mode
// (RQ4) standby keeps support on, accepts commands, all rails off
// (RQ5) standby entered on wake high with pins low, or power-down command bit
// (RQ6) any fault forces standby
// (RQ7) active reported only with a rail on and no fault
// (RQ8) in active, pin falling edge disables, rising edge enables its rail
// (RQ9) wake rising with any pin high goes active via sequence registers
// (RQ10) wake rising with pins low enters standby, rails off until pin rises
// (RQ11) wake falling while active drops rails in reverse order before sleep
// (RQ12) wake high, rails drop in pin-fall order, standby once all low
// (RQ13) faults or power-down bit drop all rails in reverse sequence order
// (RQ14) from standby rails follow pin rising order
// (RQ15) power-up bit written 1 in standby raises rails in sequence order
// (RQ16) wake falling with no rail on moves standby to sleep
// (RQ17) host holds wake low at least 150 ms
// (RQ18) hot flag set when reading reaches hot threshold, default 0x8c
// (RQ19) hot flag cleared only when reading crosses cool threshold, default 0x82
// (RQ20) wake pin deglitch 93.75 us, switch pin 62.52 us, rail pins none
// (RQ21) pin 0 neg ldo and common_voltage_driver, 1 neg pump, 2 pos ldo, 3 pos pump
// (RQ22) direct wake starts first rail 5.5 ms after wake rises
// (RQ23) faults beat simultaneous pin edges and commands; fault shutdown completes first
module pms_mode_ctrl #(
    parameter WAKE_DELAY_CYC = `PMS_WAKE_DELAY_CYC,
    parameter STEP_DELAY_CYC = `PMS_STEP_DELAY_CYC
) (
    input  wire        clk,
    input  wire        nrst,
    input  wire        wake_pin,
    input  wire [3:0]  rail_enable_bus,
    input  wire        common_switch_control_pin,
    input  wire        input_undervoltage_lockout,
    input  wire        boost_undervoltage_flag,
    input  wire        inverter_undervoltage_flag,
    input  wire        thermal_trip,
    input  wire [7:0]  temp_reading,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    output reg  [3:0]  rail_en_q,
    output reg         common_switch_en_q,
    output reg  [1:0]  mode_q,
    output reg         hot_q
);
    localparam ST_SLEEP   = 3'h0;
    localparam ST_STANDBY = 3'h1;
    localparam ST_ACTIVE  = 3'h2;
    localparam ST_WAKEDLY = 3'h3;
    localparam ST_SEQUP   = 3'h4;
    localparam ST_SEQDN   = 3'h5;

    localparam [16:0] WAKE_DG = `PMS_WAKE_DEGLITCH_CYC;
    localparam [16:0] VCSW_DG = `PMS_VCSW_DEGLITCH_CYC;
    localparam [19:0] WAKE_DLY = WAKE_DELAY_CYC;
    localparam [19:0] STEP_DLY = STEP_DELAY_CYC;

    // two-stage synchronisers; only stage two is read by logic
    reg [5:0] sync1_q;
    reg [5:0] sync2_q;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
        end else begin
            sync1_q <= {common_switch_control_pin, wake_pin, rail_enable_bus};
            sync2_q <= sync1_q;
        end
    end
    wire [3:0] pins_s  = sync2_q[3:0]; // RQ20
    wire       wake_s  = sync2_q[4];
    wire       vcsw_s  = sync2_q[5];

    // wake and switch deglitch: level must stay for the full window
    reg        wake_f_q;
    reg [16:0] wake_cnt_q;
    reg        vcsw_f_q;
    reg [16:0] vcsw_cnt_q;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wake_f_q   <= 1'b0;
            wake_cnt_q <= 17'h00000;
            vcsw_f_q   <= 1'b0;
            vcsw_cnt_q <= 17'h00000;
        end else begin
            if (wake_s == wake_f_q)
                wake_cnt_q <= 17'h00000;
            else if (wake_cnt_q >= WAKE_DG - 17'h00001) begin
                wake_f_q   <= wake_s; // RQ20
                wake_cnt_q <= 17'h00000;
            end else
                wake_cnt_q <= wake_cnt_q + 17'h00001;
            if (vcsw_s == vcsw_f_q)
                vcsw_cnt_q <= 17'h00000;
            else if (vcsw_cnt_q >= VCSW_DG - 17'h00001) begin
                vcsw_f_q   <= vcsw_s; // RQ20
                vcsw_cnt_q <= 17'h00000;
            end else
                vcsw_cnt_q <= vcsw_cnt_q + 17'h00001;
        end
    end

    reg [3:0] pins_prev_q;
    reg       wake_prev_q;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pins_prev_q <= 4'h0;
            wake_prev_q <= 1'b0;
        end else begin
            pins_prev_q <= pins_s;
            wake_prev_q <= wake_f_q;
        end
    end
    wire [3:0] pin_rise = pins_s & ~pins_prev_q;
    wire [3:0] pin_fall = ~pins_s & pins_prev_q;
    wire       wake_rise = wake_f_q & ~wake_prev_q;

    wire fault = input_undervoltage_lockout | boost_undervoltage_flag |
                 inverter_undervoltage_flag | thermal_trip;

    reg [2:0]  st_q;
    reg [19:0] dly_q;
    reg [2:0]  step_q;
    reg        to_sleep_q;
    reg [7:0]  seq_q;
    reg [7:0]  hot_thr_q;
    reg [7:0]  cool_thr_q;
    reg        cmd_up_q;
    reg        cmd_dn_q;

    // sequence register: two bits per step, slot k names the rail for step k
    wire [1:0] up_rail = seq_q[{step_q[1:0], 1'b0} +: 2];
    wire [1:0] dn_rail = seq_q[{~step_q[1:0], 1'b0} +: 2];

    // bus: one wait cycle, then answer; sleep ignores everything
    wire bus_req = (avs_read | avs_write) & (st_q != ST_SLEEP);
    wire wr_ok   = avs_write & bus_req & ~avs_waitrequest;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
            seq_q           <= `PMS_SEQ_DEFAULT;
            hot_thr_q       <= `PMS_HOT_DEFAULT;
            cool_thr_q      <= `PMS_COOL_DEFAULT;
            cmd_up_q        <= 1'b0;
            cmd_dn_q        <= 1'b0;
        end else begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            cmd_up_q        <= 1'b0;
            cmd_dn_q        <= 1'b0;
            if (st_q == ST_SLEEP) begin
                seq_q      <= `PMS_SEQ_DEFAULT; // RQ2
                hot_thr_q  <= `PMS_HOT_DEFAULT;
                cool_thr_q <= `PMS_COOL_DEFAULT;
            end else if (wr_ok) begin
                case (avs_address)
                    `PMS_REG_ENABLE: begin
                        cmd_up_q <= avs_writedata[`PMS_EN_ACTIVE_BIT];
                        cmd_dn_q <= avs_writedata[`PMS_EN_STANDBY_BIT];
                    end
                    `PMS_REG_SEQ:  seq_q <= avs_writedata[7:0];
                    `PMS_REG_TEMP: begin
                        hot_thr_q  <= avs_writedata[7:0];
                        cool_thr_q <= avs_writedata[15:8];
                    end
                    default: ;
                endcase
            end
            if (bus_req & avs_waitrequest & avs_read) begin
                case (avs_address)
                    `PMS_REG_SEQ:    avs_readdata <= {24'h000000, seq_q};
                    `PMS_REG_TEMP:   avs_readdata <= {16'h0000, cool_thr_q, hot_thr_q};
                    `PMS_REG_STATUS: avs_readdata <= {16'h0000, temp_reading, 1'b0, fault,
                                                      hot_q, st_q == ST_SLEEP, rail_en_q};
                    default:         avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    // hot flag with hysteresis
    always @(posedge clk or negedge nrst) begin
        if (!nrst)
            hot_q <= 1'b0;
        else if (temp_reading >= hot_thr_q)
            hot_q <= 1'b1; // RQ18
        else if (temp_reading < cool_thr_q)
            hot_q <= 1'b0; // RQ19
    end

    // main mode machine
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q       <= ST_SLEEP;
            rail_en_q  <= 4'h0;
            dly_q      <= 20'h00000;
            step_q     <= 3'h0;
            to_sleep_q <= 1'b0;
        end else begin
            case (st_q)
                ST_SLEEP: begin
                    rail_en_q <= 4'h0;
                    if (wake_rise && pins_s != 4'h0) begin
                        st_q  <= ST_WAKEDLY; // RQ9
                        dly_q <= 20'h00000;
                    end else if (wake_rise)
                        st_q <= ST_STANDBY; // RQ10
                end
                ST_STANDBY: begin
                    if (!wake_f_q)
                        st_q <= ST_SLEEP; // RQ16
                    else if (fault)
                        st_q <= ST_STANDBY; // RQ23
                    else if (cmd_up_q) begin
                        st_q   <= ST_SEQUP; // RQ15
                        step_q <= 3'h0;
                        dly_q  <= 20'h00000;
                    end else if (pin_rise != 4'h0) begin
                        rail_en_q <= pin_rise; // RQ14
                        st_q      <= ST_ACTIVE;
                    end
                end
                ST_WAKEDLY: begin
                    if (!wake_f_q)
                        st_q <= ST_SLEEP; // RQ3
                    else if (fault)
                        st_q <= ST_STANDBY; // RQ6
                    else if (dly_q >= WAKE_DLY - 20'h00001) begin
                        st_q   <= ST_SEQUP; // RQ22
                        step_q <= 3'h0;
                        dly_q  <= STEP_DLY;
                    end else
                        dly_q <= dly_q + 20'h00001;
                end
                ST_SEQUP: begin
                    // pin activity ignored while raising
                    if (!wake_f_q || fault || cmd_dn_q) begin
                        st_q       <= ST_SEQDN; // RQ13
                        to_sleep_q <= ~wake_f_q;
                        step_q     <= 3'h0;
                        dly_q      <= 20'h00000;
                    end else if (step_q == 3'h4)
                        st_q <= ST_ACTIVE;
                    else if (dly_q >= STEP_DLY - 20'h00001) begin
                        rail_en_q[up_rail] <= 1'b1; // RQ15
                        step_q             <= step_q + 3'h1;
                        dly_q              <= 20'h00000;
                    end else
                        dly_q <= dly_q + 20'h00001;
                end
                ST_ACTIVE: begin
                    if (!wake_f_q || fault || cmd_dn_q) begin
                        st_q       <= ST_SEQDN; // RQ11 RQ13 RQ23
                        to_sleep_q <= ~wake_f_q;
                        step_q     <= 3'h0;
                        dly_q      <= 20'h00000;
                    end else begin
                        rail_en_q <= (rail_en_q | pin_rise) & ~pin_fall; // RQ8 RQ12
                        if (((rail_en_q | pin_rise) & ~pin_fall) == 4'h0)
                            st_q <= ST_STANDBY; // RQ12
                    end
                end
                ST_SEQDN: begin
                    // fault shutdown finishes before any new request
                    if (step_q == 3'h4) begin
                        st_q <= to_sleep_q ? ST_SLEEP : ST_STANDBY; // RQ11 RQ5
                    end else if (rail_en_q[dn_rail] == 1'b0 || dly_q >= STEP_DLY - 20'h00001) begin
                        rail_en_q[dn_rail] <= 1'b0; // RQ13
                        step_q             <= step_q + 3'h1;
                        dly_q              <= 20'h00000;
                    end else
                        dly_q <= dly_q + 20'h00001;
                end
                default: st_q <= ST_SLEEP;
            endcase
        end
    end

    // mode and common_voltage_driver switch outputs
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_q             <= `PMS_MODE_SLEEP;
            common_switch_en_q <= 1'b0;
        end else begin
            if (st_q == ST_SLEEP)
                mode_q <= `PMS_MODE_SLEEP; // RQ1
            else if (rail_en_q != 4'h0 && !fault)
                mode_q <= `PMS_MODE_ACTIVE; // RQ7
            else
                mode_q <= `PMS_MODE_STANDBY; // RQ4
            common_switch_en_q <= vcsw_f_q & rail_en_q[0]; // RQ21
        end
    end
endmodule
`default_nettype wire

// file: bench/pms_mode_monitor.sv
/*
 * port checker of the operating-mode controller.
 * assumes it is bound into pms_mode_ctrl and that clk is the only clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pms_consts.vh"
module pms_mode_monitor #(
    parameter WAKE_DELAY_CYC = 50,
    parameter STEP_DELAY_CYC = 10
) (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       wake_pin,
    input wire logic [3:0] rail_enable_bus,
    input wire logic       input_undervoltage_lockout,
    input wire logic       boost_undervoltage_flag,
    input wire logic       inverter_undervoltage_flag,
    input wire logic       thermal_trip,
    input wire logic [7:0] temp_reading,
    input wire logic       avs_waitrequest,
    input wire logic [3:0] rail_en_q,
    input wire logic       common_switch_en_q,
    input wire logic [1:0] mode_q,
    input wire logic       hot_q
);
    // deglitch plus a full reverse shutdown, with slack
    localparam int LIM = 9400 + 5 * STEP_DELAY_CYC;
    wire logic flt = input_undervoltage_lockout | boost_undervoltage_flag | inverter_undervoltage_flag | thermal_trip;
    int low_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            low_q <= 0;
        else if (wake_pin)
            low_q <= 0;
        else if (low_q < LIM)
            low_q <= low_q + 1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_sleep_no_ack: assert property (
        mode_q == `PMS_MODE_SLEEP |-> avs_waitrequest) else $error("bus answered in sleep");
    a_sleep_rails_off: assert property (
        mode_q == `PMS_MODE_SLEEP |-> rail_en_q == 4'h0) else $error("rail on in sleep");
    a_standby_rails_off: assert property (
        (mode_q == `PMS_MODE_STANDBY && !flt)[*3] |-> $past(rail_en_q) == 4'h0) else $error("rail on in standby");
    a_active_has_rail: assert property (
        mode_q == `PMS_MODE_ACTIVE |-> rail_en_q != 4'h0 || $past(rail_en_q) != 4'h0) else $error("active, no rail");
    a_fault_not_active: assert property (
        flt[*3] |-> mode_q != `PMS_MODE_ACTIVE) else $error("active during fault");
    a_wake_low_sleep: assert property (
        low_q == LIM |-> mode_q == `PMS_MODE_SLEEP) else $error("no sleep after long wake low");
    a_pin_fall_off: assert property (
        $fell(rail_enable_bus[0]) && mode_q == `PMS_MODE_ACTIVE |-> ##[1:5] !rail_en_q[0]) else $error("rail kept");
    a_switch_rail0: assert property (
        common_switch_en_q |-> $past(rail_en_q[0])) else $error("switch without rail 0");
    a_hot_set: assert property (
        (mode_q != `PMS_MODE_SLEEP && temp_reading >= 8'h8c)[*3] |-> hot_q) else $error("hot not flagged");
    a_hot_hold: assert property (
        hot_q && temp_reading >= 8'h82 && mode_q != `PMS_MODE_SLEEP |=> hot_q || mode_q == `PMS_MODE_SLEEP)
        else $error("hot cleared early");
endmodule
bind pms_mode_ctrl pms_mode_monitor #(.WAKE_DELAY_CYC(WAKE_DELAY_CYC), .STEP_DELAY_CYC(STEP_DELAY_CYC)) u_mon (
    .clk(clk), .nrst(nrst), .wake_pin(wake_pin), .rail_enable_bus(rail_enable_bus),
    .input_undervoltage_lockout(input_undervoltage_lockout), .boost_undervoltage_flag(boost_undervoltage_flag),
    .inverter_undervoltage_flag(inverter_undervoltage_flag), .thermal_trip(thermal_trip),
    .temp_reading(temp_reading), .avs_waitrequest(avs_waitrequest), .rail_en_q(rail_en_q),
    .common_switch_en_q(common_switch_en_q), .mode_q(mode_q), .hot_q(hot_q));
`default_nettype wire

// file: bench/pms_host_model.sv
/*
 * host model driving the wake pin and the rail-enable pins.
 * assumes requests from the bench; pins change right after clk rises.
 */
`timescale 1ns/1ps
`default_nettype none
module pms_host_model #(
    parameter int WAKE_LOW_CYC = 200
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       wake_req,
    input  wire logic [3:0] rail_req,
    output var  logic       wake_pin,
    output var  logic [3:0] rail_enable_bus
);
    // low hold is scaled down: the real minimum would outlast the run
    int hold_q;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wake_pin <= 1'b0;
            rail_enable_bus <= 4'h0;
            hold_q <= 0;
        end else begin
            rail_enable_bus <= rail_req;
            if (!wake_pin && hold_q < WAKE_LOW_CYC)
                hold_q <= hold_q + 1;
            else if (wake_pin != wake_req) begin
                wake_pin <= wake_req;
                hold_q <= 0;
            end
        end
    end
endmodule
`default_nettype wire

// file: bench/pms_mode_ctrl_tb.sv
/*
 * self-checking bench of the operating-mode controller.
 * assumes the bound port checker and the host model beside it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pms_consts.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module pms_mode_ctrl_tb;
    logic        clk = 0, nrst = 0, wake_req = 0, csw_pin = 0, avs_read = 0, avs_write = 0, ok;
    logic [3:0]  rail_req = 0, flt = 0, avs_address = 0;
    logic [7:0]  temp = 8'h00;
    logic [31:0] avs_writedata = 0, rd;
    wire logic        wake_pin, avs_waitrequest, csw_en, hot_q;
    wire logic [3:0]  pins, rail_en_q;
    wire logic [1:0]  mode_q;
    wire logic [31:0] avs_readdata;
    int mismatches = 0, compares = 0, t0, i;
    logic [8:0]  rows [6] = '{9'h080, 9'h08b, 9'h18c, 9'h183, 9'h182, 9'h081};
    logic [35:0] regs [3] = '{{4'h4, 32'he4}, {4'h8, 32'h828c}, {4'h0, 32'h0}};
    always #5 clk = ~clk;
    pms_host_model host (.clk(clk), .nrst(nrst), .wake_req(wake_req), .rail_req(rail_req), .wake_pin(wake_pin),
        .rail_enable_bus(pins));
    pms_mode_ctrl #(.WAKE_DELAY_CYC(50), .STEP_DELAY_CYC(10)) dut (.clk(clk), .nrst(nrst), .wake_pin(wake_pin),
        .rail_enable_bus(pins), .common_switch_control_pin(csw_pin), .input_undervoltage_lockout(flt[0]),
        .boost_undervoltage_flag(flt[1]), .inverter_undervoltage_flag(flt[2]), .thermal_trip(flt[3]),
        .temp_reading(temp), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rail_en_q(rail_en_q), .common_switch_en_q(csw_en), .mode_q(mode_q), .hot_q(hot_q));
    task test_done;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // request held until waitrequest is seen low at a rising edge, or for 50 rising edges at most
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q, output logic k);
        int n;
        n = 0;
        k = 0;
        @(posedge clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        while (!k && n < 50) begin
            @(posedge clk);
            k = (avs_waitrequest === 1'b0);
            n++;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task wait_rails(input logic [3:0] e);
        int n;
        n = 0;
        while (rail_en_q !== e && n < 12000) begin
            @(negedge clk);
            n++;
        end
        `CHK("rails", e, rail_en_q)
    endtask
    task wait_mode(input logic [1:0] m);
        int n;
        n = 0;
        while (mode_q !== m && n < 12000) begin
            @(negedge clk);
            n++;
        end
        `CHK("mode", m, mode_q)
    endtask
    // walks the slots of a sequence word, up in order or down reversed
    task seq_run(input logic [7:0] s, input logic up);
        logic [3:0] acc;
        acc = up ? 4'h0 : 4'hf;
        for (int k = 0; k < 4; k++) begin
            if (up)
                acc[s[2*k+:2]] = 1'b1;
            else
                acc[s[6-2*k+:2]] = 1'b0;
            wait_rails(acc);
        end
    endtask
    initial begin
        #900000;
        mismatches++;
        test_done;
    end
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        `CHK("mode", `PMS_MODE_SLEEP, mode_q)
        bus(0, 4'h4, 0, rd, ok);
        `CHK("ack", 1'b0, ok)
        wake_req <= 1'b1;
        csw_pin <= 1'b1;
        wait_mode(`PMS_MODE_STANDBY);
        foreach (regs[j]) begin
            bus(0, regs[j][35:32], 0, rd, ok);
            `CHK("reg", regs[j][31:0], rd)
        end
        foreach (rows[j]) begin
            temp <= rows[j][7:0];
            repeat (4) @(posedge clk);
            `CHK("hot", rows[j][8], hot_q)
        end
        rail_req <= 4'h4;
        wait_rails(4'h4);
        rail_req <= 4'h5;
        wait_rails(4'h5);
        `CHK("mode", `PMS_MODE_ACTIVE, mode_q)
        @(negedge clk);
        `CHK("switch", 1'b1, csw_en)
        rail_req <= 4'h1;
        wait_rails(4'h1);
        rail_req <= 4'h0;
        wait_mode(`PMS_MODE_STANDBY);
        bus(1, 4'h4, 32'h1b, rd, ok);
        for (i = 0; i < 5; i++) begin
            bus(1, 4'h0, 32'h1, rd, ok);
            seq_run(8'h1b, 1);
            if (i < 4)
                flt <= 4'h1 << i;
            else
                bus(1, 4'h0, 32'h2, rd, ok);
            seq_run(8'h1b, 0);
            wait_mode(`PMS_MODE_STANDBY);
            flt <= 4'h0;
        end
        wake_req <= 1'b0;
        wait_mode(`PMS_MODE_SLEEP);
        rail_req <= 4'h2;
        wake_req <= 1'b1;
        t0 = $time / 10;
        wait_rails(4'h1);
        `CHK("delay", 1'b1, ($time / 10 - t0) inside {[9425:9450]})
        seq_run(8'he4, 1);
        wake_req <= 1'b0;
        seq_run(8'he4, 0);
        wait_mode(`PMS_MODE_SLEEP);
        // let the long-low watch in the checker run out
        repeat (200) @(negedge clk);
        test_done;
    end
endmodule
`default_nettype wire
